//--- rtl/kbw_pkg.sv
// shared constants and types of the keyboard/mouse wake and isolation block
package kbw_pkg;
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFS_WAKE_STS = 8'h00;
   localparam logic [7:0]  OFS_WAKE_CLR = 8'h04;
   localparam logic [7:0]  OFS_WAKE_EN  = 8'h08;
   localparam logic [7:0]  OFS_GLOBAL   = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_EN   = 8'h10;
   localparam logic [7:0]  OFS_LIVE     = 8'h14;
   localparam logic [7:0]  OFS_GCFG     = 8'h2C;
   localparam logic [7:0]  OFS_CTRL     = 8'hF0;
   localparam logic [7:0]  RST_GCFG     = 8'h00;
   localparam logic [7:0]  RST_CTRL     = 8'h00;
   localparam int unsigned BIT_KBC_RST  = 6;
   localparam int unsigned BIT_M_ISO    = 6;
   localparam int unsigned BIT_K_ISO    = 5;
   localparam int unsigned BIT_M_LATCH  = 4;
   localparam int unsigned BIT_K_LATCH  = 3;
   localparam int unsigned NEV          = 4;
   localparam int unsigned EV_KIRQ      = 0;
   localparam int unsigned EV_MIRQ      = 1;
   localparam int unsigned EV_KBD_DATA_LINE      = 2;
   localparam int unsigned EV_MOUSE_DATA_LINE      = 3;
   localparam int unsigned NLINE        = 4;
   localparam int unsigned LN_KBD_CLOCK_LINE      = 0;
   localparam int unsigned LN_KBD_DATA_LINE      = 1;
   localparam int unsigned LN_MCLK      = 2;
   localparam int unsigned LN_MOUSE_DATA_LINE      = 3;
   localparam int unsigned LN_MPWR      = 4;
   localparam int unsigned NSYNC        = 5;
   localparam logic        LINE_IDLE    = 1'b1;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_type;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_type;
endpackage : kbw_pkg

//--- rtl/edge_if.sv
// synchronised line level and falling-edge pulse
`timescale 1ns/1ps
interface edge_if;
   logic lvl;
   logic fall;
   modport src (output lvl, output fall);
   modport dst (input lvl, input fall);
endinterface : edge_if

//--- rtl/data_edge_detect.sv
// two-flop synchroniser with falling-edge detector for one line
`timescale 1ns/1ps
module data_edge_detect (
   input  wire logic clk_i,  // block clock
   input  wire logic rst_i,  // synchronous reset
   input  wire logic line_i, // asynchronous line
   edge_if.src       eo      // synced level and edge
);
   import kbw_pkg::*;
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic fall;
   } sync_state_type;
   sync_state_type s_r;
   sync_state_type s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.meta = line_i;
      s_nxt.sync = s_r.meta;
      s_nxt.prev = s_r.sync;
      s_nxt.fall = s_r.prev && !s_r.sync;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{meta: LINE_IDLE, sync: LINE_IDLE, prev: LINE_IDLE, fall: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign eo.lvl  = s_r.sync;
   assign eo.fall = s_r.fall;

   property p_fall_once;
      @(posedge clk_i) disable iff (rst_i) eo.fall |=> !eo.fall;
   endproperty
   a_fall_once: assert property (p_fall_once) else $error("edge pulse longer than one cycle");

   property p_fall_cause;
      @(posedge clk_i) disable iff (rst_i) $fell(eo.lvl) |=> eo.fall;
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("falling edge not flagged");
endmodule : data_edge_detect

//--- rtl/kbd_mouse_wake_isolation.sv
// keyboard/mouse irq latches, wake status, line isolation, AXI4-Lite registers
//
// Notes on behaviour
// - mouse latch select bit 4: 0 gives irq AND latched copy, 1 latched copy.
// - keyboard latch select bit 3: 0 gives irq AND latched copy, 1 latched copy.
// - keyboard and mouse interrupts set their own wake status bits.
// - falling edges of keyboard and mouse data lines set their own status bits.
// - status drives the wake event only with its enable and global enable set.
// - interrupt wake events occur only while main supply is present.
// - data-edge wake events work with or without main supply.
// - mouse isolate bit 6 blocks mouse clock and data into the controller.
// - keyboard isolate bit 5 blocks keyboard clock and data into the controller.
// - bit 6 of register 0x2C holds the controller in reset; never self-clears.
`timescale 1ns/1ps
module kbd_mouse_wake_isolation (
   input  wire logic                       clk_i,         // 25 MHz clock
   input  wire logic                       rst_i,         // sync reset, high
   input  wire logic [kbw_pkg::ADDR_W-1:0] awaddr_i,      // write address
   input  wire logic                       awvalid_i,     // write address valid
   output logic                            awready_o,     // write address ready
   input  wire logic [31:0]                wdata_i,       // write data
   input  wire logic [3:0]                 wstrb_i,       // write strobes
   input  wire logic                       wvalid_i,      // write data valid
   output logic                            wready_o,      // write data ready
   output logic [1:0]                      bresp_o,       // write response
   output logic                            bvalid_o,      // write response valid
   input  wire logic                       bready_i,      // write response ready
   input  wire logic [kbw_pkg::ADDR_W-1:0] araddr_i,      // read address
   input  wire logic                       arvalid_i,     // read address valid
   output logic                            arready_o,     // read address ready
   output logic [31:0]                     rdata_o,       // read data
   output logic [1:0]                      rresp_o,       // read response
   output logic                            rvalid_o,      // read data valid
   input  wire logic                       rready_i,      // read data ready
   input  wire logic                       kbd_irq_i,     // controller keyboard irq
   input  wire logic                       mouse_irq_i,   // controller mouse irq
   input  wire logic                       kbd_irq_ack_i, // clears keyboard latch
   input  wire logic                       mouse_irq_ack_i, // clears mouse latch
   output logic                            kbd_irq_o,     // selected keyboard irq
   output logic                            mouse_irq_o,   // selected mouse irq
   input  wire logic [kbw_pkg::NLINE-1:0]  line_i,        // pins: kbd_clock_line,kbd_data_line,mclk,mouse_data_line
   output logic [kbw_pkg::NLINE-1:0]       line_o,        // pin drive value
   output logic [kbw_pkg::NLINE-1:0]       line_oe_o,     // pin drive enable
   input  wire logic [kbw_pkg::NLINE-1:0]  kbc_drive_i,   // controller pulls line low
   output logic [kbw_pkg::NLINE-1:0]       kbc_line_o,    // lines seen by controller
   output logic                            kbc_reset_o,   // controller held in reset
   input  wire logic                       main_power_i,  // main supply present
   output logic                            pme_o,         // wake event, high
   output logic                            irq_o          // interrupt, high
);
   import kbw_pkg::*;

   typedef struct packed {
      wr_state_type     wst;
      logic             aw_got;
      logic             w_got;
      logic [7:0]       waddr;
      logic [7:0]       wdata;
      logic             wlane;
      logic [1:0]       bresp;
      rd_state_type     rst;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic [7:0]       gcfg;
      logic [7:0]       ctrl;
      logic [NEV-1:0]   sts;
      logic [NEV-1:0]   wake_en;
      logic             glb_en;
      logic [NEV-1:0]   irq_en;
      logic             kbd_irq_latch_sel;
      logic             mouse_irq_latch_sel;
      logic             kirq;
      logic             mirq;
      logic             pme;
      logic             irq;
      logic [NLINE-1:0] kbc_line;
      logic [NLINE-1:0] oe;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   logic [NSYNC-1:0] lvl;
   logic [NSYNC-1:0] fall;
   logic [NSYNC-1:0] raw;
   logic [NEV-1:0]   ev_set;
   logic [NEV-1:0]   ev_clr;
   logic             mpwr;
   logic             aw_take;
   logic             w_take;
   logic             ar_take;
   logic             wr_do;
   logic             k_iso;
   logic             m_iso;

   assign raw = {main_power_i, line_i};

   // line and supply synchronisers
   generate
      for (genvar g = 0; g < NSYNC; g++) begin : g_sync
         edge_if e ();
         data_edge_detect u_det (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .line_i (raw[g]),
            .eo     (e)
         );
         assign lvl[g]  = e.lvl;
         assign fall[g] = e.fall;
      end
   endgenerate

   assign mpwr  = lvl[LN_MPWR];
   assign k_iso = s_r.ctrl[BIT_K_ISO];
   assign m_iso = s_r.ctrl[BIT_M_ISO];

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_WAKE_STS) || (a == OFS_WAKE_CLR) || (a == OFS_WAKE_EN) ||
               (a == OFS_GLOBAL) || (a == OFS_IRQ_EN) || (a == OFS_LIVE) ||
               (a == OFS_GCFG) || (a == OFS_CTRL);
   endfunction : mapped

   assign awready_o = (s_r.wst == WR_IDLE) && !s_r.aw_got;
   assign wready_o  = (s_r.wst == WR_IDLE) && !s_r.w_got;
   assign bvalid_o  = (s_r.wst == WR_RESP);
   assign arready_o = (s_r.rst == RD_IDLE);
   assign rvalid_o  = (s_r.rst == RD_DATA);
   assign aw_take   = awvalid_i && awready_o;
   assign w_take    = wvalid_i && wready_o;
   assign ar_take   = arvalid_i && arready_o;
   assign wr_do     = (s_r.wst == WR_IDLE) && s_r.aw_got && s_r.w_got;

   // wake events
   always_comb begin
      ev_set          = '0;
      ev_set[EV_KIRQ] = kbd_irq_i && mpwr;
      ev_set[EV_MIRQ] = mouse_irq_i && mpwr;
      ev_set[EV_KBD_DATA_LINE] = fall[LN_KBD_DATA_LINE];
      ev_set[EV_MOUSE_DATA_LINE] = fall[LN_MOUSE_DATA_LINE];
   end

   always_comb begin
      s_nxt  = s_r;
      ev_clr = '0;
      // write address and data, either order
      if (aw_take) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr  = awaddr_i;
      end
      if (w_take) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = wdata_i[7:0];
         s_nxt.wlane = wstrb_i[0];
      end
      if (wr_do) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.wst    = WR_RESP;
         s_nxt.bresp  = mapped(s_r.waddr) ? RESP_OKAY : RESP_SLVERR;
         if (s_r.wlane) begin
            case (s_r.waddr)
               OFS_WAKE_CLR: begin
                  ev_clr = s_r.wdata[NEV-1:0];
               end
               OFS_WAKE_EN: begin
                  s_nxt.wake_en = s_r.wdata[NEV-1:0];
               end
               OFS_GLOBAL: begin
                  s_nxt.glb_en = s_r.wdata[0];
               end
               OFS_IRQ_EN: begin
                  s_nxt.irq_en = s_r.wdata[NEV-1:0];
               end
               OFS_GCFG: begin
                  s_nxt.gcfg = s_r.wdata;
               end
               OFS_CTRL: begin
                  s_nxt.ctrl = s_r.wdata;
               end
               default: begin
               end
            endcase
         end
      end
      if ((s_r.wst == WR_RESP) && bready_i) begin
         s_nxt.wst = WR_IDLE;
      end

      // read channel
      if (ar_take) begin
         s_nxt.rst   = RD_DATA;
         s_nxt.rresp = mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
         s_nxt.rdata = '0;
         case (araddr_i)
            OFS_WAKE_STS: begin
               s_nxt.rdata[NEV-1:0] = s_r.sts;
            end
            OFS_WAKE_EN: begin
               s_nxt.rdata[NEV-1:0] = s_r.wake_en;
            end
            OFS_GLOBAL: begin
               s_nxt.rdata[0] = s_r.glb_en;
            end
            OFS_IRQ_EN: begin
               s_nxt.rdata[NEV-1:0] = s_r.irq_en;
            end
            OFS_LIVE: begin
               s_nxt.rdata[NSYNC-1:0] = lvl;
               s_nxt.rdata[NSYNC]     = s_r.kbd_irq_latch_sel;
               s_nxt.rdata[NSYNC+1]   = s_r.mouse_irq_latch_sel;
            end
            OFS_GCFG: begin
               s_nxt.rdata[7:0] = s_r.gcfg;
            end
            OFS_CTRL: begin
               s_nxt.rdata[7:0] = s_r.ctrl;
            end
            default: begin
            end
         endcase
      end else if ((s_r.rst == RD_DATA) && rready_i) begin
         s_nxt.rst = RD_IDLE;
      end

      // sticky status, a set in the clearing cycle wins
      s_nxt.sts = (s_r.sts & ~ev_clr) | ev_set;

      // irq latches, set wins over acknowledge
      s_nxt.kbd_irq_latch_sel = kbd_irq_i || (s_r.kbd_irq_latch_sel && !kbd_irq_ack_i);
      s_nxt.mouse_irq_latch_sel = mouse_irq_i || (s_r.mouse_irq_latch_sel && !mouse_irq_ack_i);
      s_nxt.kirq   = s_r.ctrl[BIT_K_LATCH] ? s_r.kbd_irq_latch_sel
                                           : (kbd_irq_i && s_r.kbd_irq_latch_sel);
      s_nxt.mirq   = s_r.ctrl[BIT_M_LATCH] ? s_r.mouse_irq_latch_sel
                                           : (mouse_irq_i && s_r.mouse_irq_latch_sel);

      s_nxt.pme = s_r.glb_en && |(s_r.sts & s_r.wake_en);
      s_nxt.irq = |(s_r.sts & s_r.irq_en);

      // isolation: controller sees idle-high lines, cannot drive them
      s_nxt.kbc_line[LN_KBD_CLOCK_LINE] = k_iso ? LINE_IDLE : lvl[LN_KBD_CLOCK_LINE];
      s_nxt.kbc_line[LN_KBD_DATA_LINE] = k_iso ? LINE_IDLE : lvl[LN_KBD_DATA_LINE];
      s_nxt.kbc_line[LN_MCLK] = m_iso ? LINE_IDLE : lvl[LN_MCLK];
      s_nxt.kbc_line[LN_MOUSE_DATA_LINE] = m_iso ? LINE_IDLE : lvl[LN_MOUSE_DATA_LINE];
      s_nxt.oe[LN_KBD_CLOCK_LINE] = kbc_drive_i[LN_KBD_CLOCK_LINE] && !k_iso;
      s_nxt.oe[LN_KBD_DATA_LINE] = kbc_drive_i[LN_KBD_DATA_LINE] && !k_iso;
      s_nxt.oe[LN_MCLK] = kbc_drive_i[LN_MCLK] && !m_iso;
      s_nxt.oe[LN_MOUSE_DATA_LINE] = kbc_drive_i[LN_MOUSE_DATA_LINE] && !m_iso;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r          <= '0;
         s_r.wst      <= WR_IDLE;
         s_r.rst      <= RD_IDLE;
         s_r.gcfg     <= RST_GCFG;
         s_r.ctrl     <= RST_CTRL;
         s_r.kbc_line <= {NLINE{LINE_IDLE}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bresp_o     = s_r.bresp;
   assign rdata_o     = s_r.rdata;
   assign rresp_o     = s_r.rresp;
   assign kbd_irq_o   = s_r.kirq;
   assign mouse_irq_o = s_r.mirq;
   assign line_o      = '0;
   assign line_oe_o   = s_r.oe;
   assign kbc_line_o  = s_r.kbc_line;
   assign kbc_reset_o = s_r.gcfg[BIT_KBC_RST];
   assign pme_o       = s_r.pme;
   assign irq_o       = s_r.irq;

   property p_mouse_sel;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |=> mouse_irq_o == ($past(s_r.ctrl[BIT_M_LATCH]) ? $past(s_r.mouse_irq_latch_sel)
                                  : ($past(mouse_irq_i) && $past(s_r.mouse_irq_latch_sel)));
   endproperty
   a_mouse_sel: assert property (p_mouse_sel) else $error("mouse irq select wrong");

   property p_kbd_sel;
      @(posedge clk_i) disable iff (rst_i)
         (s_r.ctrl[BIT_K_LATCH] && s_r.kbd_irq_latch_sel && !kbd_irq_i) |=> kbd_irq_o;
   endproperty
   a_kbd_sel: assert property (p_kbd_sel) else $error("keyboard latched irq lost");

   property p_kirq_sts;
      @(posedge clk_i) disable iff (rst_i) (kbd_irq_i && mpwr) |=> s_r.sts[EV_KIRQ];
   endproperty
   a_kirq_sts: assert property (p_kirq_sts) else $error("keyboard irq status not set");

   property p_mouse_data_line_sts;
      @(posedge clk_i) disable iff (rst_i) fall[LN_MOUSE_DATA_LINE] |=> s_r.sts[EV_MOUSE_DATA_LINE];
   endproperty
   a_mouse_data_line_sts: assert property (p_mouse_data_line_sts) else $error("mouse data status not set");

   property p_pme;
      @(posedge clk_i) disable iff (rst_i)
         (s_r.sts[EV_KBD_DATA_LINE] && s_r.wake_en[EV_KBD_DATA_LINE] && s_r.glb_en) ##1 s_r.sts[EV_KBD_DATA_LINE] |-> pme_o;
   endproperty
   a_pme: assert property (p_pme) else $error("wake event missing");

   property p_no_pme;
      @(posedge clk_i) disable iff (rst_i) !s_r.glb_en |=> !pme_o;
   endproperty
   a_no_pme: assert property (p_no_pme) else $error("wake event without global enable");

   property p_irq_power;
      @(posedge clk_i) disable iff (rst_i)
         $rose(s_r.sts[EV_MIRQ]) |-> $past(mpwr) && $past(mouse_irq_i);
   endproperty
   a_irq_power: assert property (p_irq_power) else $error("irq wake on standby");

   property p_edge_standby;
      @(posedge clk_i) disable iff (rst_i) (fall[LN_KBD_DATA_LINE] && !mpwr) |=> s_r.sts[EV_KBD_DATA_LINE];
   endproperty
   a_edge_standby: assert property (p_edge_standby) else $error("edge lost on standby");

   property p_m_iso;
      @(posedge clk_i) disable iff (rst_i)
         m_iso |=> (kbc_line_o[LN_MCLK] && kbc_line_o[LN_MOUSE_DATA_LINE] && !line_oe_o[LN_MCLK]);
   endproperty
   a_m_iso: assert property (p_m_iso) else $error("mouse lines not isolated");

   property p_k_iso;
      @(posedge clk_i) disable iff (rst_i)
         k_iso |=> (kbc_line_o[LN_KBD_CLOCK_LINE] && kbc_line_o[LN_KBD_DATA_LINE] && !line_oe_o[LN_KBD_DATA_LINE]);
   endproperty
   a_k_iso: assert property (p_k_iso) else $error("keyboard lines not isolated");

   property p_kbc_hold;
      @(posedge clk_i) disable iff (rst_i) (kbc_reset_o && !wr_do) |=> kbc_reset_o;
   endproperty
   a_kbc_hold: assert property (p_kbc_hold) else $error("controller reset self-cleared");

   property p_sts_hold;
      @(posedge clk_i) disable iff (rst_i)
         (s_r.sts[EV_MOUSE_DATA_LINE] && !ev_clr[EV_MOUSE_DATA_LINE]) |=> s_r.sts[EV_MOUSE_DATA_LINE];
   endproperty
   a_sts_hold: assert property (p_sts_hold) else $error("status bit lost");

   property p_mirq_sts;
      @(posedge clk_i) disable iff (rst_i) (mouse_irq_i && mpwr) |=> s_r.sts[EV_MIRQ];
   endproperty
   a_mirq_sts: assert property (p_mirq_sts) else $error("mouse irq status not set");
endmodule : kbd_mouse_wake_isolation

//--- tb/kbd_partner.sv
// keyboard and mouse side model: open-drain frame starts on data and clock lines
`timescale 1ns/1ps
module kbd_partner (
   input  wire logic       clk_i,  // block clock
   input  wire logic       go_i,   // start a frame
   input  wire logic       ch_i,   // 0 keyboard, 1 mouse
   input  wire logic [4:0] len_i,  // frame length in cycles
   output logic [3:0]      pull_o, // pulls line low
   output logic            busy_o  // frame under way
);
   logic [4:0] cnt_r;
   logic       ch_r;
   initial begin
      cnt_r = 5'h00;
      ch_r  = 1'b0;
   end
   always @(posedge clk_i) begin
      if (go_i) begin
         cnt_r <= len_i;
         ch_r  <= ch_i;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
   // data held low all frame, clock toggles only inside it; released lines float to pull-up
   always_comb begin
      pull_o = 4'h0;
      if (cnt_r != 5'h00) begin
         pull_o[{ch_r, 1'b1}] = 1'b1;
         pull_o[{ch_r, 1'b0}] = cnt_r[0];
      end
   end
   assign busy_o = (cnt_r != 5'h00);
endmodule : kbd_partner

//--- tb/tb.sv
// self-checking bench of the keyboard/mouse wake and isolation block
`timescale 1ns/1ps
module tb;
   import kbw_pkg::*;
   logic        clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, kbc_rst, mp, pme, irq_o, go, ch, busy;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, seed, rd, r;
   logic [1:0]  bresp, rresp, rs, irq, ack, iso;
   logic [3:0]  line_o, line_oe, drive, kbc_line, pull, sts;
   logic [4:0]  len;
   wire  [3:0]  line_w;
   wire  [1:0]  irq_out;
   int          failures, n_tests, cc;
   assign line_w = ~(pull | line_oe);
   kbd_mouse_wake_isolation dut (
      .clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
      .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid),
      .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
      .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
      .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .kbd_irq_i(irq[0]),
      .mouse_irq_i(irq[1]), .kbd_irq_ack_i(ack[0]), .mouse_irq_ack_i(ack[1]),
      .kbd_irq_o(irq_out[0]), .mouse_irq_o(irq_out[1]), .line_i(line_w), .line_o(line_o),
      .line_oe_o(line_oe), .kbc_drive_i(drive), .kbc_line_o(kbc_line),
      .kbc_reset_o(kbc_rst), .main_power_i(mp), .pme_o(pme), .irq_o(irq_o));
   kbd_partner far (.clk_i(clk_i), .go_i(go), .ch_i(ch), .len_i(len), .pull_o(pull),
      .busy_o(busy));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic exp_pme(input logic g, input logic [3:0] s, input logic [3:0] e);
      return g & (|(s & e));
   endfunction : exp_pme
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic da, dw, ea, ew;
      @(posedge clk_i);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      while (!(da && dw)) begin
         @(negedge clk_i);
         ea = !da && (awready === 1'b1);
         ew = !dw && (wready === 1'b1);
         @(posedge clk_i);
         if (ea) awvalid <= 1'b0;
         if (ew) wvalid <= 1'b0;
         da = da | ea;
         dw = dw | ew;
      end
      do @(negedge clk_i); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge clk_i);
      bready <= 1'b0;
   endtask : wr
   task automatic rd32(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(negedge clk_i); while (arready !== 1'b1);
      @(posedge clk_i);
      arvalid <= 1'b0;
      do @(negedge clk_i); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      @(posedge clk_i);
      rready <= 1'b0;
   endtask : rd32
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
      rd32(a, rd, rs);
      check(what, rd, e);
      check("rresp", rs, RESP_OKAY);
   endtask : rchk
   task automatic tally_and_finish();
      $display("checks %0d, failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      tally_and_finish();
   end
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      {irq, ack, drive, go, ch, len} = '0;
      mp = 1'b1;
      rst_i = 1'b1;
      seed = 32'h44C5B452;
      failures = 0;
      n_tests = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wt(1);
      check("kbc_line reset", kbc_line, 32'hF);
      rchk("gcfg reset", OFS_GCFG, 32'h0);
      rchk("ctrl reset", OFS_CTRL, 32'h0);
      rchk("live reset", OFS_LIVE, 32'h1F);
      rd32(8'h40, rd, rs);
      check("unmapped rresp", rs, RESP_SLVERR);
      check("unmapped rdata", rd, 32'h0);
      wr(8'h40, 32'hFF, rs);
      check("unmapped bresp", rs, RESP_SLVERR);
      $display("test registers done");
      wr(OFS_GCFG, 32'h40, rs);
      check("gcfg bresp", rs, RESP_OKAY);
      wt(2);
      check("kbc reset set", kbc_rst, 32'h1);
      wt(30);
      check("kbc reset held", kbc_rst, 32'h1);
      rchk("gcfg readback", OFS_GCFG, 32'h40);
      wr(OFS_GCFG, 32'h00, rs);
      wt(2);
      check("kbc reset off", kbc_rst, 32'h0);
      $display("test controller reset done");
      for (int k = 0; k < 2; k++) begin
         for (int s = 0; s < 2; s++) begin
            wr(OFS_CTRL, 32'(s << (BIT_K_LATCH + k)), rs);
            @(posedge clk_i) irq[k] <= 1'b1;
            wt(3);
            check("irq out high", irq_out[k], 32'h1);
            @(posedge clk_i) irq[k] <= 1'b0;
            wt(3);
            check("irq after drop", irq_out[k], 32'(s));
            @(posedge clk_i) ack[k] <= 1'b1;
            @(posedge clk_i) ack[k] <= 1'b0;
            wt(3);
            check("irq after ack", irq_out[k], 32'h0);
            rchk("sts irq", OFS_WAKE_STS, 32'(1 << k));
            wr(OFS_WAKE_CLR, 32'hF, rs);
         end
      end
      @(posedge clk_i) mp <= 1'b0;
      wt(4);
      @(posedge clk_i) irq <= 2'b11;
      @(posedge clk_i) irq <= 2'b00;
      wt(3);
      rchk("sts without main", OFS_WAKE_STS, 32'h0);
      @(posedge clk_i) ack <= 2'b11;
      @(posedge clk_i) ack <= 2'b00;
      $display("test irq latch done");
      for (int i = 0; i < 6; i++) begin
         r = xs();
         cc = (i < 2) ? i : int'(r[0]);
         iso = (i < 2) ? 2'(i * 3) : r[2:1];
         wr(OFS_CTRL, 32'({iso, 5'h00}), rs);
         @(posedge clk_i) begin
            mp  <= (i < 2) ? 1'b0 : r[3];
            go  <= 1'b1;
            ch  <= cc[0];
            len <= 5'h0A + {1'b0, r[7:4]};
         end
         @(posedge clk_i) go <= 1'b0;
         wt(6);
         check("kbc data line", kbc_line[2*cc+1], 32'(iso[cc]));
         if (iso[cc]) check("kbc clock line", kbc_line[2*cc], 32'h1);
         do @(negedge clk_i); while (busy);
         wt(8);
         rchk("sts data edge", OFS_WAKE_STS, 32'(1 << (2 + cc)));
         wr(OFS_WAKE_CLR, 32'hF, rs);
         rchk("sts once", OFS_WAKE_STS, 32'h0);
      end
      @(posedge clk_i) mp <= 1'b1;
      $display("test data edges done");
      for (int j = 0; j < 2; j++) begin
         wr(OFS_CTRL, (j == 0) ? 32'h60 : 32'h00, rs);
         @(posedge clk_i) drive <= 4'hF;
         wt(4);
         check("controller drive", line_oe, (j == 0) ? 32'h0 : 32'hF);
         check("line_o", line_o, 32'h0);
         @(posedge clk_i) drive <= 4'h0;
         wt(8);
      end
      @(posedge clk_i) irq <= 2'b11;
      @(posedge clk_i) irq <= 2'b00;
      wt(4);
      r = xs();
      wr(OFS_WAKE_CLR, 32'(r[3:0]), rs);
      sts = 4'hF & ~r[3:0];
      rchk("sts partial clear", OFS_WAKE_STS, 32'(sts));
      for (int i = 0; i < 8; i++) begin
         r = (i == 0) ? 32'h1FF : xs();
         wr(OFS_WAKE_EN, 32'(r[3:0]), rs);
         wr(OFS_GLOBAL, 32'(r[4]), rs);
         wr(OFS_IRQ_EN, 32'(r[8:5]), rs);
         wt(3);
         check("pme", pme, 32'(exp_pme(r[4], sts, r[3:0])));
         check("irq_o", irq_o, 32'(|(sts & r[8:5])));
         rchk("wake_en readback", OFS_WAKE_EN, 32'(r[3:0]));
         rchk("global readback", OFS_GLOBAL, 32'(r[4]));
         rchk("irq_en readback", OFS_IRQ_EN, 32'(r[8:5]));
      end
      wr(OFS_WAKE_CLR, 32'hF, rs);
      wt(3);
      check("pme cleared", pme, 32'h0);
      check("irq_o cleared", irq_o, 32'h0);
      $display("test wake event done");
      tally_and_finish();
   end
endmodule : tb
